//--- tmc_timer0_counter_compare.sv
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tmc_timer0_counter_compare
	import tmc_timer_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic externalCountInput,
	input wire logic globalIrqEnable,
	input wire logic ovfIrqAck,
	input wire logic cmpIrqAck,
	output logic ovfIrqReq,
	output logic cmpIrqReq,
	output logic compareOutputPin
);

	// Bus data phase tracking
	logic dphValid_ff; // Data phase pending
	logic dphWrite_ff; // Pending transfer is a write
	logic [TMC_ADDR_W-1:0] dphAddr_ff; // Latched byte offset
	logic hreadyout_ff; // Wait state control
	logic [31:0] hrdata_ff; // Registered read data

	// Software visible state
	logic [2:0] clockSourceSelect_ff;
	logic [1:0] waveformModeSelect_ff;
	logic [1:0] compareOutputAction_ff;
	logic [7:0] timerCount_ff; // Timer count value
	logic [7:0] cmpBuffer_ff; // Compare buffer, CPU side
	logic [7:0] cmpActive_ff; // Compare value seen by comparator
	logic ovfFlag_ff;
	logic cmpFlag_ff;
	logic ovfMask_ff;
	logic cmpMask_ff;

	// Counter internals
	logic countDown_ff; // Direction, phase correct mode only
	logic matchBlock_ff; // Set by a count write
	logic [TMC_PRE_W-1:0] prescale_ff; // Free running prescaler
	logic extSync1_ff; // First synchroniser stage
	logic extSync2_ff; // Second synchroniser stage
	logic extPrev_ff; // Previous synchronised level
	logic compareOut_ff; // Waveform output state
	logic ovfIrq_ff;
	logic cmpIrq_ff;

	// Next values
	logic [7:0] nxt_timerCount;
	logic nxt_countDown;
	logic nxt_compareOut;
	logic [31:0] nxt_hrdata;

	// Address phase accept and data phase completion
	wire addrAccept = hsel && htrans[1] && hready;
	wire dphDone = dphValid_ff && !hreadyout_ff;
	wire busWrite = dphDone && dphWrite_ff;
	wire busRead = dphDone && !dphWrite_ff;

	// Register write decode
	wire wrCtrl = busWrite && (dphAddr_ff == TMC_OFS_CTRL);
	wire wrCount = busWrite && (dphAddr_ff == TMC_OFS_COUNT);
	wire wrCmp = busWrite && (dphAddr_ff == TMC_OFS_CMP);
	wire wrFlag = busWrite && (dphAddr_ff == TMC_OFS_FLAG);
	wire wrMask = busWrite && (dphAddr_ff == TMC_OFS_MASK);

	// Mode decode; odd codes are the PWM modes
	wire pwmMode = waveformModeSelect_ff[0];
	wire modeNormal = waveformModeSelect_ff == TMC_WGM_NORMAL;
	wire modeCtc = waveformModeSelect_ff == TMC_WGM_CTC;
	wire modeFast = waveformModeSelect_ff == TMC_WGM_FASTPWM;
	wire modePc = waveformModeSelect_ff == TMC_WGM_PCPWM;

	// Force strobe obeys the mode and action written with it, so one write sets the pin
	wire [1:0] wrMode = hwdata[TMC_WGM_LSB +: 2];
	wire forceCompare = wrCtrl && hwdata[TMC_FOC_BIT] && !wrMode[0];
	// Action used on a non-PWM match; a forced one takes the freshly written bits
	wire [1:0] nonPwmAction = forceCompare ? hwdata[TMC_COM_LSB +: 2] : compareOutputAction_ff;

	// Extremes of the count
	wire atBottom = timerCount_ff == TMC_BOTTOM;
	wire atMax = timerCount_ff == TMC_MAX;

	// Comparator, always active
	wire compareEqual = timerCount_ff == cmpActive_ff;

	// External edge detect works on the second stage only
	wire extRise = extSync2_ff && !extPrev_ff;
	wire extFall = !extSync2_ff && extPrev_ff;

	// Prescaler taps
	wire pre8 = (prescale_ff & TMC_PRE_M8) == TMC_PRE_M8;
	wire pre64 = (prescale_ff & TMC_PRE_M64) == TMC_PRE_M64;
	wire pre256 = (prescale_ff & TMC_PRE_M256) == TMC_PRE_M256;
	wire pre1024 = (prescale_ff & TMC_PRE_M1024) == TMC_PRE_M1024;

	// Timer tick from the selected source and edge
	logic timerTick;
	always_comb
	begin
		unique case (clockSourceSelect_ff)
			TMC_CS_STOP: timerTick = 1'b0;
			TMC_CS_DIV1: timerTick = 1'b1;
			TMC_CS_DIV8: timerTick = pre8;
			TMC_CS_DIV64: timerTick = pre64;
			TMC_CS_DIV256: timerTick = pre256;
			TMC_CS_DIV1024: timerTick = pre1024;
			TMC_CS_EXT_FALL: timerTick = extFall;
			TMC_CS_EXT_RISE: timerTick = extRise;
		endcase
	end

	// A match acts one tick after the count reached it, unless blocked
	wire matchHit = timerTick && compareEqual && !matchBlock_ff;

	// Overflow point per mode: wrap from max, or bottom turn in phase correct
	wire ovfSet = timerTick && (modePc ? (atBottom && countDown_ff) : atMax);

	// Top for buffer transfer: max in both PWM modes
	wire cmpLoad = pwmMode && timerTick && atMax;

	// Counter sequence
	always_comb
	begin
		nxt_timerCount = timerCount_ff;
		nxt_countDown = countDown_ff && modePc;
		if (wrCount)
		begin
			// CPU write wins over any tick
			nxt_timerCount = hwdata[7:0];
		end
		else if (timerTick)
		begin
			if (modeCtc && matchHit)
			begin
				// Compare value acts as top
				nxt_timerCount = TMC_BOTTOM;
			end
			else if (modePc)
			begin
				// Turn at max and at bottom
				if (!countDown_ff && atMax)
				begin
					nxt_countDown = 1'b1;
					nxt_timerCount = timerCount_ff - TMC_ONE;
				end
				else if (countDown_ff && atBottom)
				begin
					nxt_countDown = 1'b0;
					nxt_timerCount = timerCount_ff + TMC_ONE;
				end
				else if (countDown_ff)
				begin
					nxt_timerCount = timerCount_ff - TMC_ONE;
				end
				else
				begin
					nxt_timerCount = timerCount_ff + TMC_ONE;
				end
			end
			else
			begin
				// Normal, fast PWM and CLEAR_ON_MATCH_MODE without match wrap at max
				nxt_timerCount = timerCount_ff + TMC_ONE;
			end
		end
	end

	// Waveform generator
	always_comb
	begin
		nxt_compareOut = compareOut_ff;
		if (forceCompare || ((modeNormal || modeCtc) && matchHit))
		begin
			// Non-PWM: act on a real or forced match
			unique case (nonPwmAction)
				TMC_COM_NONE: nxt_compareOut = compareOut_ff;
				TMC_COM_TOGGLE: nxt_compareOut = !compareOut_ff;
				TMC_COM_CLEAR: nxt_compareOut = 1'b0;
				TMC_COM_SET: nxt_compareOut = 1'b1;
			endcase
		end
		else if (modeFast)
		begin
			// Match first, wrap to bottom last, so compare at max holds steady
			if (compareOutputAction_ff[1] && matchHit)
			begin
				nxt_compareOut = compareOutputAction_ff[0];
			end
			if (compareOutputAction_ff[1] && timerTick && atMax)
			begin
				nxt_compareOut = !compareOutputAction_ff[0];
			end
		end
		else
		begin
			// Phase correct: level follows direction of the match
			if (compareOutputAction_ff[1] && matchHit)
			begin
				nxt_compareOut = compareOutputAction_ff[0] ^ countDown_ff;
			end
		end
	end

	// Register read multiplexer
	always_comb
	begin
		nxt_hrdata = TMC_RST_WORD;
		unique case (dphAddr_ff)
			TMC_OFS_CTRL:
			begin
				nxt_hrdata[TMC_CS_LSB +: 3] = clockSourceSelect_ff;
				nxt_hrdata[TMC_WGM_LSB +: 2] = waveformModeSelect_ff;
				nxt_hrdata[TMC_COM_LSB +: 2] = compareOutputAction_ff;
			end
			TMC_OFS_COUNT: nxt_hrdata[7:0] = timerCount_ff;
			TMC_OFS_CMP: nxt_hrdata[7:0] = pwmMode ? cmpBuffer_ff : cmpActive_ff;
			TMC_OFS_FLAG:
			begin
				nxt_hrdata[TMC_OVF_BIT] = ovfFlag_ff;
				nxt_hrdata[TMC_CMP_BIT] = cmpFlag_ff;
			end
			TMC_OFS_MASK:
			begin
				nxt_hrdata[TMC_OVF_BIT] = ovfMask_ff;
				nxt_hrdata[TMC_CMP_BIT] = cmpMask_ff;
			end
			default: nxt_hrdata = TMC_RST_WORD; // Unmapped reads zero
		endcase
	end

	// Bus slave: one wait state so read data comes from a flop
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			dphValid_ff <= 1'b0;
			dphWrite_ff <= 1'b0;
			dphAddr_ff <= TMC_RST_BYTE;
			hreadyout_ff <= 1'b1;
			hrdata_ff <= TMC_RST_WORD;
		end
		else if (addrAccept)
		begin
			dphValid_ff <= 1'b1;
			dphWrite_ff <= hwrite;
			dphAddr_ff <= haddr[TMC_ADDR_W-1:0];
			hreadyout_ff <= 1'b0;
		end
		else if (dphDone)
		begin
			dphValid_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
			if (busRead)
			begin
				hrdata_ff <= nxt_hrdata;
			end
		end
	end

	// Control and mask registers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			clockSourceSelect_ff <= TMC_CS_STOP;
			waveformModeSelect_ff <= TMC_WGM_NORMAL;
			compareOutputAction_ff <= TMC_COM_NONE;
			ovfMask_ff <= 1'b0;
			cmpMask_ff <= 1'b0;
		end
		else
		begin
			if (wrCtrl)
			begin
				clockSourceSelect_ff <= hwdata[TMC_CS_LSB +: 3];
				waveformModeSelect_ff <= hwdata[TMC_WGM_LSB +: 2];
				// Action bits are not buffered; effective immediately
				compareOutputAction_ff <= hwdata[TMC_COM_LSB +: 2];
			end
			if (wrMask)
			begin
				ovfMask_ff <= hwdata[TMC_OVF_BIT];
				cmpMask_ff <= hwdata[TMC_CMP_BIT];
			end
		end
	end

	// Compare buffer and active compare value
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cmpBuffer_ff <= TMC_RST_BYTE;
			cmpActive_ff <= TMC_RST_BYTE;
		end
		else
		begin
			if (wrCmp)
			begin
				cmpBuffer_ff <= hwdata[7:0];
			end
			if (wrCmp && !pwmMode)
			begin
				cmpActive_ff <= hwdata[7:0];
			end
			else if (cmpLoad)
			begin
				// Glitch-free update only at top
				cmpActive_ff <= cmpBuffer_ff;
			end
		end
	end

	// Counter, direction and match blocking
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			timerCount_ff <= TMC_RST_BYTE;
			countDown_ff <= 1'b0;
			matchBlock_ff <= 1'b0;
		end
		else
		begin
			timerCount_ff <= nxt_timerCount;
			countDown_ff <= nxt_countDown;
			// Held until a tick consumes it, even while stopped
			if (wrCount)
			begin
				matchBlock_ff <= 1'b1;
			end
			else if (timerTick)
			begin
				matchBlock_ff <= 1'b0;
			end
		end
	end

	// Interrupt flags: a set in the same cycle beats any clear
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			ovfFlag_ff <= 1'b0;
			cmpFlag_ff <= 1'b0;
		end
		else
		begin
			if (ovfSet)
			begin
				ovfFlag_ff <= 1'b1;
			end
			else if (ovfIrqAck || (wrFlag && hwdata[TMC_OVF_BIT]))
			begin
				ovfFlag_ff <= 1'b0;
			end
			if (matchHit)
			begin
				cmpFlag_ff <= 1'b1;
			end
			else if (cmpIrqAck || (wrFlag && hwdata[TMC_CMP_BIT]))
			begin
				cmpFlag_ff <= 1'b0;
			end
		end
	end

	// Prescaler, external synchroniser and output stage
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			prescale_ff <= 10'h000;
			extSync1_ff <= 1'b0;
			extSync2_ff <= 1'b0;
			extPrev_ff <= 1'b0;
			compareOut_ff <= 1'b0;
			ovfIrq_ff <= 1'b0;
			cmpIrq_ff <= 1'b0;
		end
		else
		begin
			prescale_ff <= prescale_ff + 10'h001;
			extSync1_ff <= externalCountInput;
			extSync2_ff <= extSync1_ff;
			extPrev_ff <= extSync2_ff;
			compareOut_ff <= nxt_compareOut;
			ovfIrq_ff <= ovfFlag_ff && ovfMask_ff && globalIrqEnable;
			cmpIrq_ff <= cmpFlag_ff && cmpMask_ff && globalIrqEnable;
		end
	end

	// Outputs straight from flops, except hresp, which is a constant
	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0; // Always OKAY
	assign ovfIrqReq = ovfIrq_ff;
	assign cmpIrqReq = cmpIrq_ff;
	assign compareOutputPin = compareOut_ff;

endmodule : tmc_timer0_counter_compare

`default_nettype wire

//--- tmc_timer_pkg.sv
package tmc_timer_pkg;

	// Data widths
	localparam int TMC_CNT_W = 8;
	localparam int TMC_PRE_W = 10;

	// Register byte offsets on the bus
	localparam logic [7:0] TMC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TMC_OFS_COUNT = 8'h04;
	localparam logic [7:0] TMC_OFS_CMP = 8'h08;
	localparam logic [7:0] TMC_OFS_FLAG = 8'h0c;
	localparam logic [7:0] TMC_OFS_MASK = 8'h10;
	localparam int TMC_ADDR_W = 8;

	// Control register field positions
	localparam int TMC_CS_LSB = 0;
	localparam int TMC_WGM_LSB = 3;
	localparam int TMC_COM_LSB = 5;
	localparam int TMC_FOC_BIT = 7;

	// Flag and mask bit positions
	localparam int TMC_OVF_BIT = 0;
	localparam int TMC_CMP_BIT = 1;

	// Count extremes
	localparam logic [7:0] TMC_BOTTOM = 8'h00;
	localparam logic [7:0] TMC_MAX = 8'hff;
	localparam logic [7:0] TMC_ONE = 8'h01;

	// Clock source select codes
	localparam logic [2:0] TMC_CS_STOP = 3'h0;
	localparam logic [2:0] TMC_CS_DIV1 = 3'h1;
	localparam logic [2:0] TMC_CS_DIV8 = 3'h2;
	localparam logic [2:0] TMC_CS_DIV64 = 3'h3;
	localparam logic [2:0] TMC_CS_DIV256 = 3'h4;
	localparam logic [2:0] TMC_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TMC_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TMC_CS_EXT_RISE = 3'h7;

	// Prescaler masks: tick when all masked bits are one
	localparam logic [9:0] TMC_PRE_M1 = 10'h000;
	localparam logic [9:0] TMC_PRE_M8 = 10'h007;
	localparam logic [9:0] TMC_PRE_M64 = 10'h03f;
	localparam logic [9:0] TMC_PRE_M256 = 10'h0ff;
	localparam logic [9:0] TMC_PRE_M1024 = 10'h3ff;

	// Waveform mode select codes
	localparam logic [1:0] TMC_WGM_NORMAL = 2'h0;
	localparam logic [1:0] TMC_WGM_PCPWM = 2'h1;
	localparam logic [1:0] TMC_WGM_CTC = 2'h2;
	localparam logic [1:0] TMC_WGM_FASTPWM = 2'h3;

	// Compare output action codes
	localparam logic [1:0] TMC_COM_NONE = 2'h0;
	localparam logic [1:0] TMC_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TMC_COM_CLEAR = 2'h2;
	localparam logic [1:0] TMC_COM_SET = 2'h3;

	// Reset values
	localparam logic [7:0] TMC_RST_BYTE = 8'h00;
	localparam logic [31:0] TMC_RST_WORD = 32'h0000_0000;

endpackage : tmc_timer_pkg

//--- tmc_timer0_counter_compare_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tmc_timer0_counter_compare_properties
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic globalIrqEnable,
	input wire logic ovfIrqReq,
	input wire logic cmpIrqReq,
	input wire logic compareOutputPin
);
	// Single clock domain, synchronous reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// Each accepted transfer gets exactly one wait state
	bus_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
		else $error("wait state length wrong");
	// Never two wait cycles in a row
	no_extra_wait_a: assert property (!hreadyout |=> hreadyout)
		else $error("slave stalled too long");
	// Response is always OKAY
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	// Registers are 8 bits wide, upper read bits zero
	rdata_width_a: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// Read data only moves when a transfer completes
	rdata_hold_a: assert property ($changed(hrdata) && !$past(srst) |-> !$past(hreadyout))
		else $error("read data moved outside a transfer");
	// Requests need the global enable one cycle before
	cmp_gate_a: assert property (!globalIrqEnable |=> !cmpIrqReq)
		else $error("compare request without global enable");
	ovf_gate_a: assert property (!globalIrqEnable |=> !ovfIrqReq)
		else $error("overflow request without global enable");
	// Outputs come out of reset quiet
	reset_state_a: assert property ($fell(srst) |-> hreadyout && !cmpIrqReq && !ovfIrqReq
		&& !compareOutputPin && hrdata == 32'h0)
		else $error("outputs not cleared by reset");

	// Main scenarios reached
	cover property (hsel && htrans[1] && hready);
	cover property ($rose(cmpIrqReq));
	cover property ($rose(ovfIrqReq));
	cover property ($rose(compareOutputPin));
endmodule : tmc_timer0_counter_compare_properties

bind tmc_timer0_counter_compare tmc_timer0_counter_compare_properties u_props (.core_clk,
	.srst, .hsel, .htrans, .hready, .hrdata, .hreadyout, .hresp, .globalIrqEnable,
	.ovfIrqReq, .cmpIrqReq, .compareOutputPin);

`default_nettype wire

//--- tmc_ext_pins.sv
`timescale 1ns/1ps
`default_nettype none

module tmc_ext_pins
(
	input wire logic core_clk,
	input wire logic extGo,
	input wire logic [7:0] pulseCount,
	input wire logic [3:0] halfCycles,
	input wire logic compareOutputPin,
	output var logic externalCountInput,
	output var logic extBusy,
	output var logic [7:0] pinEdges
);
	logic pinPrev; // Output pin one cycle ago

	// Count pin rests low between trains
	initial
	begin
		externalCountInput = 1'b0;
		extBusy = 1'b0;
		pinEdges = 8'h0;
		pinPrev = 1'b0;
	end

	// Pulse train on request; width sets fast or slow source
	always
	begin
		@(posedge core_clk);
		if (extGo)
		begin
			extBusy <= 1'b1;
			repeat (pulseCount)
			begin
				externalCountInput <= 1'b1;
				repeat (halfCycles) @(posedge core_clk);
				externalCountInput <= 1'b0;
				repeat (halfCycles) @(posedge core_clk);
			end
			extBusy <= 1'b0;
		end
	end

	// Rising edges seen on the waveform output
	always @(posedge core_clk)
	begin
		pinPrev <= compareOutputPin;
		if (compareOutputPin && !pinPrev)
			pinEdges <= pinEdges + 8'h1;
	end
endmodule : tmc_ext_pins

`default_nettype wire

//--- tb_timer0_counter_compare.sv
`timescale 1ns/1ps
`default_nettype none

module tb_timer0_counter_compare
	import tmc_timer_pkg::*;
;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2; // Word transfers only
	logic [31:0] hwdata = 32'h0;
	wire logic hready; // Single slave: ready loops back
	logic [31:0] hrdata;
	logic hreadyout, hresp, ovfIrqReq, cmpIrqReq, compareOutputPin, externalCountInput;
	logic globalIrqEnable = 1'b0;
	logic ovfIrqAck = 1'b0;
	logic cmpIrqAck = 1'b0;
	logic extGo = 1'b0;
	logic extBusy;
	logic [7:0] pulseCount = 8'h5;
	logic [3:0] halfCycles = 4'h2;
	logic [7:0] pinEdges;
	int miscompares = 0;
	int checksDone = 0;

	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;
	assign hready = hreadyout;

	tmc_timer0_counter_compare uut (.core_clk(core_clk), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.externalCountInput(externalCountInput), .globalIrqEnable(globalIrqEnable),
		.ovfIrqAck(ovfIrqAck), .cmpIrqAck(cmpIrqAck), .ovfIrqReq(ovfIrqReq),
		.cmpIrqReq(cmpIrqReq), .compareOutputPin(compareOutputPin));

	tmc_ext_pins pins (.core_clk(core_clk), .extGo(extGo), .pulseCount(pulseCount),
		.halfCycles(halfCycles), .compareOutputPin(compareOutputPin),
		.externalCountInput(externalCountInput), .extBusy(extBusy), .pinEdges(pinEdges));

	task automatic complete_run;
		if (miscompares == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// Ready and read data are taken at the rising edge; only the watchdog ends a stall
	task automatic wait_rdy(output logic [31:0] d);
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		d = hrdata;
	endtask : wait_rdy

	// One single word transfer: address phase, then data phase
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] d);
		logic [31:0] x;
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(x);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(d);
	endtask : xfer

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		xfer(a, 1'b1, wd, d);
	endtask : wr_reg

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		xfer(a, 1'b0, 32'h0, d);
		check(d, e);
	endtask : chk_reg

	task automatic chk_rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] d;
		xfer(a, 1'b0, 32'h0, d);
		check({31'h0, d >= lo && d <= hi}, 32'h1);
	endtask : chk_rng

	function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wgm,
		input logic [1:0] com);
		ctl = {24'h0, 1'b0, com, wgm, cs};
	endfunction : ctl

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	// Service pulse on one request line
	task automatic pulse_ack(input logic cmp);
		@(posedge core_clk);
		cmpIrqAck <= cmp;
		ovfIrqAck <= !cmp;
		@(posedge core_clk);
		cmpIrqAck <= 1'b0;
		ovfIrqAck <= 1'b0;
		tick(2);
	endtask : pulse_ack

	// Reset values, unmapped slot, width and stopped counter
	task automatic reset_regs;
		for (int i = 0; i < 6; i++)
			chk_reg(8'(4 * i), 32'h0);
		wr_reg(8'h14, 32'hff);
		chk_reg(8'h14, 32'h0);
		wr_reg(TMC_OFS_COUNT, 32'hffff_ff5a);
		wr_reg(TMC_OFS_CMP, 32'ha5);
		tick(10);
		chk_reg(TMC_OFS_COUNT, 32'h5a);
		chk_reg(TMC_OFS_CMP, 32'ha5);
	endtask : reset_regs

	// Wrap past the maximum, masking, both ways of clearing
	task automatic overflow_run;
		int n;
		wr_reg(TMC_OFS_MASK, 32'h1);
		globalIrqEnable <= 1'b1;
		wr_reg(TMC_OFS_COUNT, 32'hf0);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_NORMAL, TMC_COM_NONE));
		n = 0;
		while (ovfIrqReq !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge core_clk);
		end
		check({31'h0, ovfIrqReq}, 32'h1);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_reg(TMC_OFS_FLAG, 32'h1);
		wr_reg(TMC_OFS_FLAG, 32'h1);
		chk_reg(TMC_OFS_FLAG, 32'h0);
		check({31'h0, ovfIrqReq}, 32'h0);
		wr_reg(TMC_OFS_MASK, 32'h0);
		wr_reg(TMC_OFS_COUNT, 32'hff);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_NORMAL, TMC_COM_NONE));
		wr_reg(TMC_OFS_CTRL, 32'h0);
		check({31'h0, ovfIrqReq}, 32'h0);
		chk_reg(TMC_OFS_FLAG, 32'h1);
		pulse_ack(1'b0);
		chk_reg(TMC_OFS_FLAG, 32'h0);
		globalIrqEnable <= 1'b0;
	endtask : overflow_run

	// Clear on match with toggling output, gated request
	task automatic ctc_run;
		logic [7:0] e0;
		wr_reg(TMC_OFS_CMP, 32'h3);
		wr_reg(TMC_OFS_COUNT, 32'h0);
		wr_reg(TMC_OFS_MASK, 32'h2);
		e0 = pinEdges;
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_CTC, TMC_COM_TOGGLE));
		for (int i = 0; i < 4; i++)
			chk_rng(TMC_OFS_COUNT, 32'h0, 32'h3);
		check({31'h0, cmpIrqReq}, 32'h0);
		globalIrqEnable <= 1'b1;
		tick(3);
		check({31'h0, cmpIrqReq}, 32'h1);
		check({31'h0, pinEdges != e0}, 32'h1);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		pulse_ack(1'b1);
		chk_reg(TMC_OFS_FLAG, 32'h0);
		globalIrqEnable <= 1'b0;
	endtask : ctc_run

	// Forced match sets, clears, and is ignored in a PWM mode
	task automatic force_run;
		wr_reg(TMC_OFS_COUNT, 32'h7);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_NORMAL, TMC_COM_SET) | 32'h80);
		tick(2);
		check({31'h0, compareOutputPin}, 32'h1);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_NORMAL, TMC_COM_CLEAR) | 32'h80);
		tick(2);
		check({31'h0, compareOutputPin}, 32'h0);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_FASTPWM, TMC_COM_SET) | 32'h80);
		tick(2);
		check({31'h0, compareOutputPin}, 32'h0);
		chk_reg(TMC_OFS_FLAG, 32'h0);
		chk_reg(TMC_OFS_COUNT, 32'h7);
	endtask : force_run

	// Count write equal to compare hides the first match
	task automatic block_run;
		wr_reg(TMC_OFS_CTRL, 32'h0);
		wr_reg(TMC_OFS_CMP, 32'h10);
		wr_reg(TMC_OFS_COUNT, 32'h10);
		tick(6);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_NORMAL, TMC_COM_NONE));
		tick(20);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_reg(TMC_OFS_FLAG, 32'h0);
	endtask : block_run

	// Buffered compare in PWM, loaded only at the maximum
	task automatic buffer_run;
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_FASTPWM, TMC_COM_NONE));
		wr_reg(TMC_OFS_CMP, 32'h40);
		chk_reg(TMC_OFS_CMP, 32'h40);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_reg(TMC_OFS_CMP, 32'h10);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_FASTPWM, TMC_COM_NONE));
		wr_reg(TMC_OFS_COUNT, 32'hfd);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_FASTPWM, TMC_COM_CLEAR));
		tick(8);
		check({31'h0, compareOutputPin}, 32'h1);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_reg(TMC_OFS_CMP, 32'h40);
	endtask : buffer_run

	// Phase correct counts up, turns at the maximum and comes back down
	task automatic pc_run;
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_STOP, TMC_WGM_PCPWM, TMC_COM_NONE));
		wr_reg(TMC_OFS_COUNT, 32'hfe);
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_PCPWM, TMC_COM_NONE));
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_rng(TMC_OFS_COUNT, 32'hf8, 32'hfd);
	endtask : pc_run

	// External pin, falling then rising edge, fast then slow source
	task automatic ext_run;
		int n;
		for (int i = 0; i < 2; i++)
		begin
			wr_reg(TMC_OFS_COUNT, 32'h0);
			wr_reg(TMC_OFS_CTRL, ctl(i ? TMC_CS_EXT_RISE : TMC_CS_EXT_FALL,
				TMC_WGM_NORMAL, TMC_COM_NONE));
			halfCycles <= 4'(2 + 4 * i);
			extGo <= 1'b1;
			@(posedge core_clk);
			extGo <= 1'b0;
			tick(2);
			n = 0;
			while (extBusy !== 1'b0 && n < 200)
			begin
				n++;
				@(negedge core_clk);
			end
			tick(6);
			wr_reg(TMC_OFS_CTRL, 32'h0);
			chk_reg(TMC_OFS_COUNT, 32'h5);
		end
	endtask : ext_run

	// Every prescaled rate for about sixteen ticks, then a count write while running
	task automatic presc_run;
		int spans[4] = '{128, 1024, 4096, 16384};
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(TMC_OFS_COUNT, 32'h0);
			wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV8 + 3'(i), TMC_WGM_NORMAL, TMC_COM_NONE));
			repeat (spans[i]) @(posedge core_clk);
			wr_reg(TMC_OFS_CTRL, 32'h0);
			chk_rng(TMC_OFS_COUNT, 32'hf, 32'h11);
		end
		wr_reg(TMC_OFS_CTRL, ctl(TMC_CS_DIV1, TMC_WGM_NORMAL, TMC_COM_NONE));
		wr_reg(TMC_OFS_COUNT, 32'h80);
		wr_reg(TMC_OFS_CTRL, 32'h0);
		chk_rng(TMC_OFS_COUNT, 32'h80, 32'h86);
	endtask : presc_run

	// Main sequence
	initial
	begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_regs();
		overflow_run();
		ctc_run();
		force_run();
		block_run();
		buffer_run();
		pc_run();
		ext_run();
		presc_run();
		complete_run();
	end

	// Watchdog well beyond the expected run of about 22000 cycles, mostly the slow prescaler
	initial
	begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		complete_run();
	end
endmodule : tb_timer0_counter_compare

`default_nettype wire
